// ==== shared/ulb_regs.svh ====
// Register map, field positions, reset values and bit-time counts
`ifndef ULB_REGS_SVH
`define ULB_REGS_SVH
`define ULB_BASE_BLOCKING 16'h0200
`define ULB_BASE_NONBLOCKING 16'h0300
`define ULB_OFS_STATUS_TWO 5'h1c
`define ULB_OFS_CTRL_THREE 5'h1e
`define ULB_STATUS_TWO_RST 8'h00
`define ULB_CTRL_THREE_RST 8'h00
`define ULB_ST_BREAK_FLAG 7
`define ULB_ST_EDGE_FLAG 6
`define ULB_ST_RX_INVERT 4
`define ULB_ST_IDLE_REPORT 3
`define ULB_ST_LONG_TX_BREAK 2
`define ULB_ST_LONG_DETECT 1
`define ULB_ST_ACTIVE 0
`define ULB_C3_NINTH_RX 7
`define ULB_C3_PIN_DIR 5
`define ULB_C3_TX_INVERT 4
`define ULB_C3_OVERRUN_EN 3
`define ULB_C3_NOISE_EN 2
`define ULB_C3_FRAMING_EN 1
`define ULB_C3_PARITY_EN 0
`define ULB_BRK_TX_SHORT 4'ha
`define ULB_BRK_TX_SHORT_NINE 4'hb
`define ULB_BRK_TX_LONG 4'hd
`define ULB_BRK_TX_LONG_NINE 4'he
`define ULB_BRK_DET_NORMAL 4'ha
`define ULB_BRK_DET_LONG 4'hb
`define ULB_CHAR_BITS 4'ha
`define ULB_CHAR_BITS_NINE 4'hb
`define ULB_BAUD_DIV 163
`define ULB_FIFO_DEPTH 32
`endif

// ==== shared/ulb_pkg.sv ====
// Types of the LIN break and edge status block
package ulb_pkg;
  typedef enum logic [2:0] {
    RX_IDLE = 3'h0,
    RX_START = 3'h1,
    RX_DATA = 3'h2,
    RX_STOP = 3'h3,
    RX_BREAK = 3'h4
  } ulb_rx_st_t;

  typedef struct packed {
    ulb_rx_st_t rx_st;
    logic [3:0] sub;
    logic [3:0] bit_cnt;
    logic [8:0] shift;
    logic [3:0] low_cnt;
    logic [3:0] high_cnt;
    logic rx_prev;
    logic idle_armed;
    logic break_detected_flag;
    logic receive_edge_flag;
    logic receive_inversion;
    logic standby_idle_report;
    logic long_break_transmit;
    logic long_break_detect_enable;
    logic receiver_active_flag;
    logic [7:0] ctrl_three;
    logic idle_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic [7:0] rdata;
    logic irq;
    logic txd;
    logic txd_oe;
    logic tx_busy;
    logic [3:0] tx_sub;
    logic [3:0] tx_bits;
    logic [7:0] div_cnt;
    logic push;
    logic [7:0] push_data;
  } ulb_state_t;
endpackage

// ==== shared/ulb_stream_if.sv ====
// Valid/ready byte stream between receiver and buffer
`timescale 1ns/100ps
`default_nettype none
interface ulb_stream_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ==== verilog/ulb_sync.sv ====
// Two-stage synchroniser with selectable reset level
`timescale 1ns/100ps
`default_nettype none
module ulb_sync #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Level in and out
  input wire logic i_d,
  output logic o_q
);
  typedef struct packed {
    logic meta;
    logic q;
  } ulb_sync_t;

  ulb_sync_t s;
  ulb_sync_t next_s;

  // First stage feeds only the second
  always_comb
  begin
    next_s.meta = i_d;
    next_s.q = s.meta;
  end

  // State register
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      s <= {RST_VAL, RST_VAL};
    else
      s <= next_s;
  end

  assign o_q = s.q;
endmodule
`default_nettype wire

// ==== verilog/ulb_fifo.sv ====
// Received-character buffer with registered output slot
`timescale 1ns/100ps
`default_nettype none
module ulb_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Fill and drain sides
  ulb_stream_if.snk s_in,
  ulb_stream_if.src s_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
    logic out_valid;
    logic [W-1:0] out_data;
  } ulb_fifo_t;

  ulb_fifo_t s;
  ulb_fifo_t next_s;
  logic take;
  logic give;
  logic load;

  // Store, prefetch into output slot, count
  always_comb
  begin
    next_s = s;
    take = s_in.valid & s_in.ready;
    give = s.out_valid & s_out.ready;
    load = (!s.out_valid | give) & (s.cnt != '0);
    if (take)
    begin
      next_s.mem[s.wr] = s_in.data;
      next_s.wr = s.wr + 1'b1;
    end
    if (load)
    begin
      next_s.out_data = s.mem[s.rd];
      next_s.rd = s.rd + 1'b1;
      next_s.out_valid = 1'b1;
    end
    else if (give)
      next_s.out_valid = 1'b0;
    next_s.cnt = s.cnt + (AW+1)'(take) - (AW+1)'(load);
  end

  // State register
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      s <= '0;
    else
      s <= next_s;
  end

  // Full stalls the receiver side
  assign s_in.ready = s.cnt < (AW+1)'(DEPTH);
  assign s_out.valid = s.out_valid;
  assign s_out.data = s.out_data;
endmodule
`default_nettype wire

// ==== verilog/ulb_top.sv ====
// LIN break detect, edge flag, inversion and control-three register block
// Contract
// R01: Break flag sets on break with detection enabled
// R02: Break flag clears only on written one
// R03: Edge flag sets on active receive edge
// R04: Edge flag holds until written one
// R05: Receive inversion inverts every received element
// R06: Standby idle flag set only if reporting
// R07: Transmit break 10/11 or 13/14 bits
// R08: Framing check independent of long transmit break
// R09: Long detection blocks framing and full flags
// R10: Long detection needs eleven low bits
// R11: Active flag from start until idle
// R12: Software checks active flag before stop
// R13: Software enables long detection on internal clock
// R14: Decode offsets at blocking and nonblocking bases
// R15: Control three at 0x1e, resets zero
// R16: Interrupt when error flag and enable set
// R17: Transmit inversion inverts every transmitted element
`timescale 1ns/100ps
`default_nettype none
`include "ulb_regs.svh"
module ulb_top #(
  parameter int unsigned BAUD_DIV = `ULB_BAUD_DIV,
  parameter int FIFO_DEPTH = `ULB_FIFO_DEPTH
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register access
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata,
  // Serial pins
  input wire logic i_rxd,
  output logic o_txd,
  output logic o_txd_oe,
  // Controls and flags from neighbouring registers
  input wire logic i_nine_bit_mode,
  input wire logic i_receiver_wakeup_standby,
  input wire logic i_send_break,
  input wire logic i_noise_flag,
  input wire logic i_parity_error_flag,
  // Received characters
  output logic o_rx_valid,
  output logic [7:0] o_rx_data,
  input wire logic i_rx_ready,
  // Status
  output logic o_idle_flag,
  output logic o_framing_error_flag,
  output logic o_overrun_flag,
  output logic o_irq
);
  localparam logic [15:0] BASE_BLK = `ULB_BASE_BLOCKING;
  localparam logic [15:0] BASE_NBLK = `ULB_BASE_NONBLOCKING;
  localparam logic [7:0] DIV_LAST = 8'(BAUD_DIV - 1);

  ulb_pkg::ulb_state_t s;
  ulb_pkg::ulb_state_t next_s;
  logic nrst_sync;
  logic rxd_s;
  logic tick;
  logic rxi;
  logic hit;
  logic wr_st;
  logic wr_c3;
  logic edge_evt;
  logic smp;
  logic pop;
  logic brk_set;
  logic frm_set;
  logic ov_set;
  logic idle_set;
  logic [3:0] nbits;
  logic [3:0] brk_thr;
  logic [3:0] char_len;
  logic [3:0] tx_len;

  ulb_stream_if #(.W(8)) rx_in_if ();
  ulb_stream_if #(.W(8)) rx_out_if ();

  // Reset release and pin synchronisers
  ulb_sync #(.RST_VAL(1'b0)) u_rst_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_d(1'b1),
    .o_q(nrst_sync)
  );
  ulb_sync #(.RST_VAL(1'b1)) u_rxd_sync (
    .i_clk(i_clk),
    .i_nrst(nrst_sync),
    .i_d(i_rxd),
    .o_q(rxd_s)
  );

  // Receive buffer
  ulb_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_nrst(nrst_sync),
    .s_in(rx_in_if.snk),
    .s_out(rx_out_if.src)
  );
  assign rx_in_if.valid = s.push;
  assign rx_in_if.data = s.push_data;
  assign rx_out_if.ready = i_rx_ready;

  // Decode and derived timing
  always_comb
  begin
    tick = s.div_cnt == 8'h00;
    rxi = rxd_s ^ s.receive_inversion; // R05
    hit = (i_addr[15:5] == BASE_BLK[15:5]) | (i_addr[15:5] == BASE_NBLK[15:5]); // R14
    wr_st = i_wr & hit & (i_addr[4:0] == `ULB_OFS_STATUS_TWO);
    wr_c3 = i_wr & hit & (i_addr[4:0] == `ULB_OFS_CTRL_THREE); // R15
    edge_evt = s.rx_prev & ~rxi; // R03
    smp = tick & (s.sub == 4'hf) & (s.rx_st inside {ulb_pkg::RX_DATA, ulb_pkg::RX_STOP,
      ulb_pkg::RX_BREAK});
    pop = rx_out_if.valid & i_rx_ready;
    nbits = i_nine_bit_mode ? 4'h9 : 4'h8;
    brk_thr = s.long_break_detect_enable ? `ULB_BRK_DET_LONG : `ULB_BRK_DET_NORMAL; // R10
    char_len = i_nine_bit_mode ? `ULB_CHAR_BITS_NINE : `ULB_CHAR_BITS;
    if (s.long_break_transmit) // R07
      tx_len = i_nine_bit_mode ? `ULB_BRK_TX_LONG_NINE : `ULB_BRK_TX_LONG;
    else
      tx_len = i_nine_bit_mode ? `ULB_BRK_TX_SHORT_NINE : `ULB_BRK_TX_SHORT;
  end

  // Next-state logic
  always_comb
  begin
    next_s = s;
    brk_set = 1'b0;
    frm_set = 1'b0;
    ov_set = 1'b0;
    idle_set = 1'b0;
    next_s.push = 1'b0;
    next_s.rx_prev = rxi;
    next_s.div_cnt = tick ? DIV_LAST : s.div_cnt - 8'h01;
    if (tick)
      next_s.sub = s.sub + 4'h1;
    // Consecutive low bit count for break recognition
    if (smp)
    begin
      next_s.low_cnt = rxi ? 4'h0 : (s.low_cnt == 4'hf ? s.low_cnt : s.low_cnt + 4'h1);
      brk_set = !rxi & s.long_break_detect_enable & (s.low_cnt + 4'h1 == brk_thr); // R01 R10
    end
    unique case (s.rx_st)
      ulb_pkg::RX_IDLE:
      begin
        if (edge_evt)
        begin
          next_s.rx_st = ulb_pkg::RX_START;
          next_s.sub = 4'h0;
          next_s.high_cnt = 4'h0;
        end
        else if (tick && s.sub == 4'hf)
        begin
          next_s.high_cnt = !rxi ? 4'h0 : (s.high_cnt == 4'hf ? s.high_cnt : s.high_cnt + 4'h1);
          if (rxi && s.idle_armed && s.high_cnt + 4'h1 == char_len)
          begin
            next_s.receiver_active_flag = 1'b0; // R11
            next_s.idle_armed = 1'b0;
            idle_set = !(i_receiver_wakeup_standby && !s.standby_idle_report); // R06
          end
        end
      end
      ulb_pkg::RX_START:
      begin
        if (tick && s.sub == 4'h7)
        begin
          if (!rxi)
          begin
            next_s.rx_st = ulb_pkg::RX_DATA;
            next_s.sub = 4'h0;
            next_s.bit_cnt = 4'h0;
            next_s.low_cnt = 4'h1;
            next_s.receiver_active_flag = 1'b1; // R11
            next_s.idle_armed = 1'b1;
          end
          else
            next_s.rx_st = ulb_pkg::RX_IDLE;
        end
      end
      ulb_pkg::RX_DATA:
      begin
        if (smp)
        begin
          next_s.shift = {rxi, s.shift[8:1]};
          next_s.bit_cnt = s.bit_cnt + 4'h1;
          if (s.bit_cnt + 4'h1 == nbits)
            next_s.rx_st = ulb_pkg::RX_STOP;
        end
      end
      ulb_pkg::RX_STOP:
      begin
        if (smp)
        begin
          // Long detection keeps the buffer and framing flag quiet
          if (!s.long_break_detect_enable) // R09
          begin
            frm_set = !rxi; // R08
            if (rx_in_if.ready)
            begin
              next_s.push = 1'b1;
              next_s.push_data = i_nine_bit_mode ? s.shift[7:0] : s.shift[8:1];
              next_s.ctrl_three[`ULB_C3_NINTH_RX] = i_nine_bit_mode & s.shift[8];
            end
            else
              ov_set = 1'b1;
          end
          next_s.rx_st = rxi ? ulb_pkg::RX_IDLE : ulb_pkg::RX_BREAK;
        end
      end
      ulb_pkg::RX_BREAK:
      begin
        if (smp && rxi)
        begin
          next_s.rx_st = ulb_pkg::RX_IDLE;
          next_s.high_cnt = 4'h1;
        end
      end
      default:
        next_s.rx_st = ulb_pkg::RX_IDLE;
    endcase

    // Sticky flags, a new event beats a clear
    next_s.break_detected_flag = brk_set |
      (s.break_detected_flag & !(wr_st & i_wdata[`ULB_ST_BREAK_FLAG])); // R01 R02
    next_s.receive_edge_flag = edge_evt |
      (s.receive_edge_flag & !(wr_st & i_wdata[`ULB_ST_EDGE_FLAG])); // R03 R04
    next_s.framing_error_flag = frm_set | (s.framing_error_flag & !pop);
    next_s.overrun_flag = ov_set | (s.overrun_flag & !pop);
    next_s.idle_flag = idle_set | (s.idle_flag & !pop);

    // Control writes
    if (wr_st)
    begin
      next_s.receive_inversion = i_wdata[`ULB_ST_RX_INVERT];
      next_s.standby_idle_report = i_wdata[`ULB_ST_IDLE_REPORT];
      next_s.long_break_transmit = i_wdata[`ULB_ST_LONG_TX_BREAK];
      next_s.long_break_detect_enable = i_wdata[`ULB_ST_LONG_DETECT];
    end
    if (wr_c3)
      next_s.ctrl_three[6:0] = i_wdata[6:0]; // R15

    // Break transmitter
    if (!s.tx_busy && i_send_break)
    begin
      next_s.tx_busy = 1'b1;
      next_s.tx_sub = 4'h0;
      next_s.tx_bits = 4'h0;
    end
    else if (s.tx_busy && tick)
    begin
      next_s.tx_sub = s.tx_sub + 4'h1;
      if (s.tx_sub == 4'hf)
      begin
        next_s.tx_bits = s.tx_bits + 4'h1;
        if (s.tx_bits + 4'h1 == tx_len) // R07
          next_s.tx_busy = 1'b0;
      end
    end
    next_s.txd = ~next_s.tx_busy ^ next_s.ctrl_three[`ULB_C3_TX_INVERT]; // R17
    next_s.txd_oe = next_s.ctrl_three[`ULB_C3_PIN_DIR];

    // Error interrupt request
    next_s.irq = (s.overrun_flag & s.ctrl_three[`ULB_C3_OVERRUN_EN]) |
      (i_noise_flag & s.ctrl_three[`ULB_C3_NOISE_EN]) |
      (s.framing_error_flag & s.ctrl_three[`ULB_C3_FRAMING_EN]) |
      (i_parity_error_flag & s.ctrl_three[`ULB_C3_PARITY_EN]); // R16

    // Read data, unmapped reads give zero
    if (i_rd)
    begin
      if (hit && i_addr[4:0] == `ULB_OFS_STATUS_TWO)
        next_s.rdata = {s.break_detected_flag, s.receive_edge_flag, 1'b0,
          s.receive_inversion, s.standby_idle_report, s.long_break_transmit,
          s.long_break_detect_enable, s.receiver_active_flag};
      else if (hit && i_addr[4:0] == `ULB_OFS_CTRL_THREE)
        next_s.rdata = s.ctrl_three;
      else
        next_s.rdata = 8'h00;
    end
  end

  // State register
  always_ff @(posedge i_clk or negedge nrst_sync)
  begin
    if (!nrst_sync)
    begin
      s <= '0;
      s.txd <= 1'b1;
      s.rx_prev <= 1'b1;
      s.ctrl_three <= `ULB_CTRL_THREE_RST; // R15
      {s.break_detected_flag, s.receive_edge_flag, s.receive_inversion,
        s.standby_idle_report, s.long_break_transmit, s.long_break_detect_enable,
        s.receiver_active_flag} <= 7'(`ULB_STATUS_TWO_RST);
    end
    else
      s <= next_s;
  end

  // Outputs
  assign o_rdata = s.rdata;
  assign o_txd = s.txd;
  assign o_txd_oe = s.txd_oe;
  assign o_rx_valid = rx_out_if.valid;
  assign o_rx_data = rx_out_if.data;
  assign o_idle_flag = s.idle_flag;
  assign o_framing_error_flag = s.framing_error_flag;
  assign o_overrun_flag = s.overrun_flag;
  assign o_irq = s.irq;

  // Ticks spent in a transmitted break
  logic [7:0] tx_ticks;
  always_ff @(posedge i_clk or negedge nrst_sync)
  begin
    if (!nrst_sync)
      tx_ticks <= 8'h00;
    else if (!s.tx_busy && i_send_break)
      tx_ticks <= 8'h00;
    else if (s.tx_busy && tick)
      tx_ticks <= tx_ticks + 8'h01;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!nrst_sync);

  AST_BRK_NEEDS_EN: assert property ($rose(s.break_detected_flag) |->
    $past(s.long_break_detect_enable) && $past(s.low_cnt) == 4'ha) // R01
    else $error("break flag set without long detection");
  AST_BRK_CLEAR: assert property ((wr_st && i_wdata[7] && !brk_set) |=>
    !s.break_detected_flag) // R02
    else $error("break flag not cleared by write one");
  AST_BRK_HOLD: assert property ((s.break_detected_flag && !(wr_st && i_wdata[7])) |=>
    s.break_detected_flag) // R02
    else $error("break flag lost without write");
  AST_EDGE_SET: assert property ((s.rx_prev && !(rxd_s ^ s.receive_inversion)) |=>
    s.receive_edge_flag) // R03
    else $error("edge flag missed active edge");
  AST_EDGE_HOLD: assert property ((s.receive_edge_flag && !wr_st) |=> s.receive_edge_flag) // R04
    else $error("edge flag dropped");
  AST_NO_PUSH_LONG: assert property ($rose(s.push) |-> !$past(s.long_break_detect_enable)) // R09
    else $error("character buffered during long detection");
  AST_NO_FRM_LONG: assert property ($rose(s.framing_error_flag) |->
    !$past(s.long_break_detect_enable)) // R09
    else $error("framing flag set during long detection");
  AST_ACTIVE_START: assert property ($rose(s.receiver_active_flag) |->
    $past(s.rx_st) == ulb_pkg::RX_START) // R11
    else $error("active flag set outside a start bit");
  AST_IRQ_FRAMING: assert property ((s.framing_error_flag && s.ctrl_three[1]) |=> o_irq) // R16
    else $error("framing interrupt not raised");
  AST_TX_LEN: assert property ($fell(s.tx_busy) |-> tx_ticks == {tx_len, 4'h0}) // R07
    else $error("break length wrong");
  AST_TX_INV: assert property ((!s.tx_busy && !i_send_break && $stable(s.ctrl_three[4])) |=>
    o_txd == !s.ctrl_three[4]) // R17
    else $error("idle transmit level wrong");

  COV_BREAK: cover property ($rose(s.break_detected_flag));
  COV_PUSH: cover property (s.push ##1 o_rx_valid);
  COV_TX_BREAK: cover property ($fell(s.tx_busy));
  COV_EDGE: cover property ($rose(s.receive_edge_flag));
endmodule
`default_nettype wire

// ==== tb/ulb_lin_node.sv ====
// Remote LIN node model driving the receive line
`timescale 1ns/100ps
`default_nettype none
module ulb_lin_node #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input wire logic i_clk,
  // Bus line towards the receiver
  output logic o_rxd
);
  logic inv = 1'b0;
  logic lvl = 1'b1;
  // Pull-up keeps the bus recessive; an inverting transceiver flips it
  assign o_rxd = lvl ^ inv;
  // Sends n bits LSB first, one bit time each, then releases the bus
  task automatic send_bits(input logic [15:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge i_clk) #1;
      lvl = bits[i];
      repeat (BIT_CLKS - 1) @(posedge i_clk);
    end
    @(posedge i_clk) #1;
    lvl = 1'b1;
    repeat (BIT_CLKS) @(posedge i_clk);
  endtask
  // Start bit, eight data bits, chosen stop level
  task automatic send_frame(input logic [7:0] b, input logic stop);
    send_bits({6'h3f, stop, b, 1'b0}, 10);
  endtask
endmodule
`default_nettype wire

// ==== tb/ulb_top_tb_top.sv ====
// Self-checking bench of the LIN break and edge status block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    num_checks++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("wrong value %s expected %h seen %h", nm, e, g); \
    end \
  end
module ulb_top_tb_top;
  localparam int BIT = 32;
  typedef struct packed {
    logic [15:0] a;
    logic w;
    logic [7:0] d;
    logic [7:0] e;
  } ulb_row_t;
  logic i_clk, i_nrst, i_wr, i_rd, i_send_break, i_rx_ready;
  logic i_nine_bit_mode, i_receiver_wakeup_standby, i_noise_flag, i_parity_error_flag;
  logic [15:0] i_addr;
  logic [7:0] i_wdata, o_rdata, o_rx_data, r, got;
  logic o_txd, o_txd_oe, o_rx_valid, o_idle_flag, o_framing_error_flag, o_overrun_flag, o_irq;
  logic ok, frm;
  wire logic rxd_line;
  int error_cnt = 0;
  int num_checks = 0;
  int n;
  ulb_row_t rows [11] = '{
    '{16'h021c, 1'b0, 8'h00, 8'h00}, '{16'h031e, 1'b0, 8'h00, 8'h00},
    '{16'h021e, 1'b1, 8'hff, 8'h00}, '{16'h031e, 1'b0, 8'h00, 8'h7f},
    '{16'h021e, 1'b1, 8'h00, 8'h00}, '{16'h031c, 1'b1, 8'hef, 8'h00},
    '{16'h021c, 1'b0, 8'h00, 8'h0e}, '{16'h021c, 1'b1, 8'h00, 8'h00},
    '{16'h041e, 1'b1, 8'hff, 8'h00}, '{16'h021e, 1'b0, 8'h00, 8'h00},
    '{16'h0400, 1'b0, 8'h00, 8'h00}};

  // Clock generation
  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  ulb_lin_node #(.BIT_CLKS(BIT)) node (.i_clk(i_clk), .o_rxd(rxd_line));

  ulb_top #(.BAUD_DIV(2), .FIFO_DEPTH(32)) uut (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
    .i_wdata(i_wdata), .o_rdata(o_rdata), .i_rxd(rxd_line), .o_txd(o_txd),
    .o_txd_oe(o_txd_oe), .i_nine_bit_mode(i_nine_bit_mode),
    .i_receiver_wakeup_standby(i_receiver_wakeup_standby), .i_send_break(i_send_break),
    .i_noise_flag(i_noise_flag), .i_parity_error_flag(i_parity_error_flag),
    .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready),
    .o_idle_flag(o_idle_flag), .o_framing_error_flag(o_framing_error_flag),
    .o_overrun_flag(o_overrun_flag), .o_irq(o_irq));

  // Register write, one strobe cycle
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge i_clk) #1;
    i_addr = a;
    i_wdata = d;
    i_wr = 1'b1;
    @(posedge i_clk) #1;
    i_wr = 1'b0;
  endtask
  // Register read, data one cycle after the strobe
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge i_clk) #1;
    i_addr = a;
    i_rd = 1'b1;
    @(posedge i_clk) #1;
    i_rd = 1'b0;
    d = o_rdata;
  endtask
  // Bounded wait for a byte, capture it with its flag, then pop it
  task automatic pop();
    ok = 1'b0;
    for (int i = 0; i < 2000 && !ok; i++)
    begin
      @(posedge i_clk) #1;
      ok = (o_rx_valid === 1'b1);
    end
    got = o_rx_data;
    frm = o_framing_error_flag;
    i_rx_ready = ok;
    @(posedge i_clk) #1;
    i_rx_ready = 1'b0;
  endtask
  // Requests a break and counts cycles at the break level
  task automatic brk(input int len, input logic lvl);
    @(posedge i_clk) #1;
    i_send_break = 1'b1;
    @(posedge i_clk) #1;
    i_send_break = 1'b0;
    n = 0;
    repeat (16 * BIT + 40)
    begin
      @(posedge i_clk) #1;
      n += (o_txd === lvl);
    end
    `CHK("break len", 1'b1, (n >= len * BIT - 2) && (n <= len * BIT + 2))
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // Watchdog against a hang
  initial
  begin
    #1000000;
    error_cnt++;
    wrap_up();
  end

  // Main sequence
  initial
  begin
    {i_nrst, i_wr, i_rd, i_send_break, i_rx_ready, i_nine_bit_mode} = 6'h00;
    {i_receiver_wakeup_standby, i_noise_flag, i_parity_error_flag} = 3'h0;
    i_addr = 16'h0000;
    i_wdata = 8'h00;
    repeat (20) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    repeat (3) @(posedge i_clk);
    // Register table, both bases, read-only bits, unmapped places
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      else
      begin
        rd(rows[i].a, r);
        `CHK("register", rows[i].e, r)
      end
    end
    // Plain frame with active flag mid-frame
    fork
      node.send_frame(8'h5a, 1'b1);
      begin
        repeat (160) @(posedge i_clk);
        rd(16'h021c, r);
        `CHK("active", 1'b1, r[0])
      end
    join
    pop();
    `CHK("rx byte", 8'h5a, got)
    repeat (12 * BIT) @(posedge i_clk);
    rd(16'h021c, r);
    `CHK("active idle", 1'b0, r[0])
    `CHK("edge set", 1'b1, r[6])
    wr(16'h021c, 8'h00);
    rd(16'h021c, r);
    `CHK("edge held", 1'b1, r[6])
    wr(16'h031c, 8'h40);
    rd(16'h021c, r);
    `CHK("edge clear", 1'b0, r[6])
    // Standby idle reporting off then on
    i_receiver_wakeup_standby = 1'b1;
    for (int k = 0; k < 2; k++)
    begin
      wr(16'h021c, k ? 8'h08 : 8'h00);
      node.send_frame(8'h33, 1'b1);
      pop();
      repeat (12 * BIT) @(posedge i_clk);
      `CHK("standby idle", k[0], o_idle_flag)
    end
    i_receiver_wakeup_standby = 1'b0;
    // Framing error with either transmit break length
    for (int k = 0; k < 2; k++)
    begin
      wr(16'h021c, k ? 8'h04 : 8'h00);
      node.send_frame(8'h01, 1'b0);
      pop();
      `CHK("framing", 1'b1, frm)
    end
    // Long break detection
    wr(16'h021c, 8'h02);
    node.send_frame(8'h01, 1'b0);
    repeat (40) @(posedge i_clk);
    `CHK("no byte", 1'b0, o_rx_valid)
    `CHK("no framing", 1'b0, o_framing_error_flag)
    node.send_bits(16'h0000, 10);
    rd(16'h021c, r);
    `CHK("ten low", 1'b0, r[7])
    node.send_bits(16'h0000, 11);
    rd(16'h021c, r);
    `CHK("break", 1'b1, r[7])
    wr(16'h021c, 8'h02);
    rd(16'h021c, r);
    `CHK("break held", 1'b1, r[7])
    wr(16'h021c, 8'h82);
    rd(16'h021c, r);
    `CHK("break clear", 1'b0, r[7])
    wr(16'h021c, 8'h00);
    // Fill the buffer past full, then drain it in order
    wr(16'h021e, 8'h08);
    for (int k = 0; k < 34; k++)
      node.send_frame(k[7:0], 1'b1);
    `CHK("overrun", 1'b1, o_overrun_flag)
    `CHK("irq overrun", 1'b1, o_irq)
    for (int k = 0; k < 33; k++)
    begin
      pop();
      `CHK("drain", k[7:0], got)
    end
    pop();
    `CHK("empty", 1'b0, ok)
    // Noise and parity interrupt enables
    for (int k = 0; k < 2; k++)
    begin
      i_noise_flag = k[0];
      i_parity_error_flag = !k[0];
      wr(16'h021e, k ? 8'h04 : 8'h01);
      repeat (3) @(posedge i_clk);
      `CHK("irq on", 1'b1, o_irq)
      wr(16'h021e, 8'h00);
      repeat (3) @(posedge i_clk);
      `CHK("irq off", 1'b0, o_irq)
    end
    // Transmitted break lengths, then inverted
    for (int k = 0; k < 4; k++)
    begin
      wr(16'h021c, k[1] ? 8'h04 : 8'h00);
      i_nine_bit_mode = k[0];
      brk((k[1] ? 13 : 10) + k[0], 1'b0);
    end
    i_nine_bit_mode = 1'b0;
    wr(16'h021c, 8'h00);
    wr(16'h021e, 8'h30);
    repeat (3) @(posedge i_clk);
    `CHK("txd inv idle", 1'b0, o_txd)
    `CHK("pin dir", 1'b1, o_txd_oe)
    brk(10, 1'b1);
    wr(16'h021e, 8'h00);
    // Nine-bit frame, ninth bit readable in control three
    i_nine_bit_mode = 1'b1;
    node.send_bits({5'h1f, 1'b1, 9'h1a5, 1'b0}, 11);
    pop();
    `CHK("nine bit byte", 8'ha5, got)
    rd(16'h021e, r);
    `CHK("ninth bit", 1'b1, r[7])
    i_nine_bit_mode = 1'b0;
    // Inverted receive line
    wr(16'h021c, 8'h10);
    node.inv = 1'b1;
    repeat (400) @(posedge i_clk);
    wr(16'h021c, 8'hd0);
    pop();
    node.send_frame(8'ha5, 1'b1);
    rd(16'h021c, r);
    `CHK("rising edge", 1'b1, r[6])
    pop();
    `CHK("inverted byte", 8'ha5, got)
    // Reset in mid-run returns pins and registers to reset values
    wr(16'h021e, 8'h30);
    @(posedge i_clk) #1;
    i_nrst = 1'b0;
    node.inv = 1'b0;
    repeat (3) @(posedge i_clk) #1;
    `CHK("reset txd", 1'b1, o_txd)
    `CHK("reset dir", 1'b0, o_txd_oe)
    i_nrst = 1'b1;
    repeat (3) @(posedge i_clk);
    rd(16'h021e, r);
    `CHK("reset ctrl", 8'h00, r)
    rd(16'h021c, r);
    `CHK("reset status", 8'h00, r)
    wrap_up();
  end
endmodule
`default_nettype wire
